// ### dtpm_monitor.sv
// Concurrent checks on the ports of the debug and trace pin multiplexer
`default_nettype none
module dtpm_monitor (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_ie,
    input wire logic [9:0] pin_pull_up,
    input wire logic [9:0] pin_pull_down,
    input wire logic ext_rst_n,
    input wire logic dbg_tms_swdio,
    input wire logic dbg_clk_level,
    input wire logic dbg_clk_rise,
    input wire logic dbg_clk_fall,
    input wire logic dbg_tdi,
    input wire logic dbg_trst_n,
    input wire logic dbg_swd_mode,
    input wire logic trc_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // Read data only stands in the cycle after a read strobe
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h8 |-> reg_rdata == 16'h0000)
        else $error("unmapped read returned data");
    a_mode_follows: assert property ($past(reg_wr) && $past(reg_addr) == 4'h5 |=> dbg_swd_mode == $past(reg_wdata[0], 2))
        else $error("serial wire mode does not follow control write");
    // ----------------------------------------
    // Pads and debug inputs
    // ----------------------------------------
    // Pad settings settle one edge after release of reset
    a_pin_reset: assert property ($fell(sys_rst) |=> pin_ie == 10'h303 && pin_pull_up == 10'h301 && pin_pull_down == 10'h002)
        else $error("pad settings wrong after reset");
    a_ext_rst_idle: assert property (!ext_rst_n [*4] |-> dbg_tms_swdio && dbg_tdi && dbg_trst_n && !dbg_clk_level && !dbg_clk_rise)
        else $error("debug inputs active under external reset");
    a_edge_excl: assert property (!(dbg_clk_rise && dbg_clk_fall))
        else $error("rise and fall pulses together");
    a_ready_reset: assert property ($fell(sys_rst) |-> trc_ready)
        else $error("trace ready low after reset");
    // ----------------------------------------
    // Trace output
    // ----------------------------------------
    // Half period of two cycles, nibble held for a whole period
    a_trc_half: assert property ($rose(pin_out[2]) |=> pin_out[2] ##1 !pin_out[2])
        else $error("trace clock half period wrong");
    a_nibble_stands: assert property ($rose(pin_out[2]) |=> $stable(pin_out[6:3]) [*3])
        else $error("trace nibble changed inside period");
endmodule // dtpm_monitor

bind dtpm_pin_mux dtpm_monitor u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_ie(pin_ie), .pin_pull_up(pin_pull_up),
    .pin_pull_down(pin_pull_down), .ext_rst_n(ext_rst_n), .dbg_tms_swdio(dbg_tms_swdio),
    .dbg_clk_level(dbg_clk_level), .dbg_clk_rise(dbg_clk_rise), .dbg_clk_fall(dbg_clk_fall),
    .dbg_tdi(dbg_tdi), .dbg_trst_n(dbg_trst_n), .dbg_swd_mode(dbg_swd_mode),
    .trc_ready(trc_ready));
`default_nettype wire

// ### dtpm_pin_mux.v
// Debug and trace pin multiplexer with register port and trace buffer
//
// How it works
// [R1] After reset the five debug pins carry the debug port function.
// [R2] Trace clock and data pins stay general purpose until software selects them.
// [R3] Pin a0 carries TMS or SWDIO, pin a1 carries TCK or SWCLK input.
// [R4] Serial wire: a0 bidirectional, shared with probe; JTAG: a0 input only.
// [R5] Pin b0 carries TDO in JTAG, viewer output in serial wire.
// [R6] Viewer output is driven on b0 only while the viewer is enabled.
// [R7] Pin b1 is TDI, b2 is TRST; neither has a serial-wire role.
// [R8] Four trace data outputs on a3..a6, trace clock on a2, viewer too.
// [R9] Reset settings of a0 and a1 pin configuration bits as specified.
// [R10] Reset settings of b0..b2 and a2..a6 pin configuration bits as specified.
// [R11] In STOP, debug-configured a0 and b0 keep their drivers regardless of standby bit.
// [R12] Software returns a1 to general purpose when debug is unused.
// [R13] Trace words pass from the trace port unit to trace pins and viewer.
// [R14] While the external reset pin is active all debug transfers are ignored.
// [R15] Serial-wire-only mode frees TDI, TDO and TRST; viewer keeps b0.
// [R16] Function select 0 connects the pin to general-purpose logic only.
// [R17] Debug inputs see idle levels when their pin is not in debug use.
`default_nettype none

`include "dtpm_regs.vh"

module dtpm_pin_mux (
    input wire core_clk,
    input wire sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // Pad side
    input wire [9:0] pin_in,
    output reg [9:0] pin_out,
    output reg [9:0] pin_oe,
    output reg [9:0] pin_ie,
    output reg [9:0] pin_pull_up,
    output reg [9:0] pin_pull_down,
    input wire ext_rst_n,
    input wire stop_mode,
    // General-purpose port logic
    input wire [9:0] gpio_out,
    output reg [9:0] gpio_in,
    // Debug access port side
    output reg dbg_tms_swdio,
    output reg dbg_clk_level,
    output reg dbg_clk_rise,
    output reg dbg_clk_fall,
    output reg dbg_tdi,
    output reg dbg_trst_n,
    output reg dbg_swd_mode,
    input wire dbg_swdio_out,
    input wire dbg_swdio_oe,
    input wire dbg_tdo,
    input wire dbg_tdo_oe,
    input wire dbg_viewer,
    // Trace port unit stream
    input wire [3:0] trc_data,
    input wire trc_valid,
    output reg trc_ready
);

// ----------------------------------------------------------------
// Configuration registers
// ----------------------------------------------------------------
reg [9:0] function_select;
reg [9:0] input_enable;
reg [9:0] output_enable;
reg [9:0] pull_up_enable;
reg [9:0] pull_down_enable;
reg [1:0] dbg_ctrl;
reg drive_in_standby;

// Synchronisers for pad levels, reset pin and link clock
reg [9:0] pin_s1;
reg [9:0] pin_s2;
reg ext_rst_s1;
reg ext_rst_s2;
reg clk_prev;

// Trace buffer and trace clock generator
reg [3:0] buf_word0;
reg [3:0] buf_word1;
reg [1:0] buf_count;
reg [3:0] half_cnt;
reg trace_clock;
reg [3:0] trace_nibble;

wire swd_mode;
wire viewer_en;
wire dbg_blocked;
wire sel_a0;
wire sel_a1;
wire sel_b0;
wire sel_b1;
wire sel_b2;
wire trace_on;
wire stby_ok;
wire clk_tick;
wire drain;
wire fill;
wire [9:0] dbg_sel;
reg [1:0] next_buf_count;

assign swd_mode = dbg_ctrl[`DTPM_CTRL_SWD_MODE];
assign viewer_en = dbg_ctrl[`DTPM_CTRL_VIEWER_EN];
// Debug traffic is frozen while the reset pin is held
assign dbg_blocked = ~ext_rst_s2; // [R14]
assign sel_a0 = function_select[`DTPM_PIN_A0]; // [R3]
assign sel_a1 = function_select[`DTPM_PIN_A1]; // [R3]
// b0 is TDO in JTAG, viewer in serial wire only while enabled
assign sel_b0 = function_select[`DTPM_PIN_B0] & (~swd_mode | viewer_en); // [R5] [R15]
// TDI and TRST have no serial-wire role and fall back to port logic
assign sel_b1 = function_select[`DTPM_PIN_B1] & ~swd_mode; // [R7] [R15]
assign sel_b2 = function_select[`DTPM_PIN_B2] & ~swd_mode; // [R7] [R15]
// Trace pins only work when clock and all data pins are selected
assign trace_on = &function_select[`DTPM_PIN_A6:`DTPM_PIN_A2]; // [R2] [R8]
assign stby_ok = ~stop_mode | drive_in_standby;
assign dbg_sel = {sel_b2, sel_b1, sel_b0, {5{trace_on}}, sel_a1, sel_a0};

// ----------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        function_select <= `DTPM_RST_FUNC_SEL; // [R1] [R2] [R9] [R10]
        input_enable <= `DTPM_RST_INPUT_EN; // [R9] [R10]
        output_enable <= `DTPM_RST_OUTPUT_EN; // [R9] [R10]
        pull_up_enable <= `DTPM_RST_PULL_UP; // [R9] [R10]
        pull_down_enable <= `DTPM_RST_PULL_DOWN; // [R9]
        dbg_ctrl <= `DTPM_RST_DBG_CTRL;
        drive_in_standby <= `DTPM_RST_STANDBY;
    end else if (reg_wr) begin
        case (reg_addr)
            `DTPM_OFS_FUNC_SEL: function_select <= reg_wdata[9:0];
            `DTPM_OFS_INPUT_EN: input_enable <= reg_wdata[9:0];
            `DTPM_OFS_OUTPUT_EN: output_enable <= reg_wdata[9:0];
            `DTPM_OFS_PULL_UP: pull_up_enable <= reg_wdata[9:0];
            `DTPM_OFS_PULL_DOWN: pull_down_enable <= reg_wdata[9:0];
            `DTPM_OFS_DBG_CTRL: dbg_ctrl <= reg_wdata[1:0];
            `DTPM_OFS_STANDBY: drive_in_standby <= reg_wdata[`DTPM_STBY_DRIVE];
            default: begin
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Register reads: data stand in the cycle after the strobe only
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
        case (reg_addr)
            `DTPM_OFS_FUNC_SEL: reg_rdata <= {6'h00, function_select};
            `DTPM_OFS_INPUT_EN: reg_rdata <= {6'h00, input_enable};
            `DTPM_OFS_OUTPUT_EN: reg_rdata <= {6'h00, output_enable};
            `DTPM_OFS_PULL_UP: reg_rdata <= {6'h00, pull_up_enable};
            `DTPM_OFS_PULL_DOWN: reg_rdata <= {6'h00, pull_down_enable};
            `DTPM_OFS_DBG_CTRL: reg_rdata <= {14'h0000, dbg_ctrl};
            `DTPM_OFS_STANDBY: reg_rdata <= {15'h0000, drive_in_standby};
            `DTPM_OFS_STATUS: reg_rdata <= {13'h0000, buf_count, dbg_blocked};
            `DTPM_OFS_PIN_LEVEL: reg_rdata <= {6'h00, pin_s2};
            default: reg_rdata <= 16'h0000; // Unmapped reads as zero
        endcase
    end else begin
        reg_rdata <= 16'h0000;
    end
end

// ----------------------------------------------------------------
// Input synchronisers: the pads and the probe clock are asynchronous
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        pin_s1 <= 10'h000;
        pin_s2 <= 10'h000;
        ext_rst_s1 <= 1'b0;
        ext_rst_s2 <= 1'b0;
        clk_prev <= 1'b0;
    end else begin
        pin_s1 <= pin_in;
        pin_s2 <= pin_s1;
        ext_rst_s1 <= ext_rst_n;
        ext_rst_s2 <= ext_rst_s1;
        clk_prev <= pin_s2[`DTPM_PIN_A1];
    end
end

// ----------------------------------------------------------------
// Debug port inputs; idle levels when the pin is not in debug use
// ----------------------------------------------------------------
assign clk_tick = sel_a1 & ~dbg_blocked; // [R14] [R17]
always @(posedge core_clk) begin
    if (sys_rst) begin
        dbg_tms_swdio <= 1'b1;
        dbg_clk_level <= 1'b0;
        dbg_clk_rise <= 1'b0;
        dbg_clk_fall <= 1'b0;
        dbg_tdi <= 1'b1;
        dbg_trst_n <= 1'b1;
        dbg_swd_mode <= 1'b0;
    end else begin
        // Pulled-up idle for data and reset, low idle for the clock
        dbg_tms_swdio <= (sel_a0 & ~dbg_blocked) ? pin_s2[`DTPM_PIN_A0] : 1'b1; // [R3] [R17]
        dbg_clk_level <= clk_tick ? pin_s2[`DTPM_PIN_A1] : 1'b0; // [R3] [R17]
        dbg_clk_rise <= clk_tick & pin_s2[`DTPM_PIN_A1] & ~clk_prev;
        dbg_clk_fall <= clk_tick & ~pin_s2[`DTPM_PIN_A1] & clk_prev;
        dbg_tdi <= (sel_b1 & ~dbg_blocked) ? pin_s2[`DTPM_PIN_B1] : 1'b1; // [R7] [R17]
        dbg_trst_n <= (sel_b2 & ~dbg_blocked) ? pin_s2[`DTPM_PIN_B2] : 1'b1; // [R7] [R17]
        dbg_swd_mode <= swd_mode;
    end
end

// ----------------------------------------------------------------
// General-purpose input path
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        gpio_in <= 10'h000;
    end else begin
        // Port logic sees the pad only when the pin is its own
        gpio_in <= pin_s2 & input_enable & ~dbg_sel; // [R16]
    end
end

// ----------------------------------------------------------------
// Two-entry trace buffer: a stall at the pins back-pressures the source
// ----------------------------------------------------------------
// A nibble leaves on each rising edge of the trace clock while the buffer holds one
assign drain = trace_on & (half_cnt == `DTPM_TRC_HALF) & ~trace_clock & (buf_count != 2'h0);
assign fill = trc_valid & trc_ready;

always @* begin
    next_buf_count = buf_count;
    if (fill & ~drain) begin
        next_buf_count = buf_count + 2'h1;
    end else if (drain & ~fill) begin
        next_buf_count = buf_count - 2'h1;
    end
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        buf_word0 <= 4'h0;
        buf_word1 <= 4'h0;
        buf_count <= 2'h0;
        trc_ready <= 1'b1;
    end else begin
        buf_count <= next_buf_count;
        trc_ready <= (next_buf_count != 2'h2);
        // Entry 0 is the head; entry 1 shifts down on a drain
        if (drain) begin
            buf_word0 <= (buf_count == 2'h2) ? buf_word1 : trc_data; // [R13]
        end else if (fill & (buf_count == 2'h0)) begin
            buf_word0 <= trc_data; // [R13]
        end
        if (fill & (buf_count == (drain ? 2'h2 : 2'h1))) begin
            buf_word1 <= trc_data;
        end
    end
end

// ----------------------------------------------------------------
// Trace clock divider and output nibble
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        half_cnt <= 4'h1;
        trace_clock <= 1'b0;
        trace_nibble <= 4'h0;
    end else if (~trace_on) begin
        // Clock parked low while the trace pins belong to the ports
        half_cnt <= 4'h1;
        trace_clock <= 1'b0;
        trace_nibble <= 4'h0;
    end else if (half_cnt == `DTPM_TRC_HALF) begin
        half_cnt <= 4'h1;
        trace_clock <= ~trace_clock;
        if (~trace_clock) begin
            trace_nibble <= drain ? buf_word0 : 4'h0; // [R8] [R13]
        end
    end else begin
        half_cnt <= half_cnt + 4'h1;
    end
end

// ----------------------------------------------------------------
// Pad drive: debug, trace or general purpose per pin
// ----------------------------------------------------------------
always @(posedge core_clk) begin
    if (sys_rst) begin
        pin_out <= 10'h000;
        pin_oe <= 10'h000;
        pin_ie <= 10'h000;
        pin_pull_up <= 10'h000;
        pin_pull_down <= 10'h000;
    end else begin
        pin_ie <= input_enable;
        pin_pull_up <= pull_up_enable;
        pin_pull_down <= pull_down_enable;
        // Ports lose their drivers in STOP unless standby drive is on
        pin_out <= gpio_out; // [R16]
        pin_oe <= output_enable & {10{stby_ok}}; // [R16]
        // a0: SWDIO shared with probe, JTAG keeps it an input; STOP ignored
        if (sel_a0) begin
            pin_out[`DTPM_PIN_A0] <= dbg_swdio_out; // [R4]
            pin_oe[`DTPM_PIN_A0] <= swd_mode & dbg_swdio_oe & ~dbg_blocked &
                output_enable[`DTPM_PIN_A0]; // [R4] [R11] [R14]
        end
        // a1: clock input only
        if (sel_a1) begin
            pin_oe[`DTPM_PIN_A1] <= 1'b0; // [R3]
        end
        // b0: TDO or viewer; STOP does not cut it
        if (sel_b0) begin
            pin_out[`DTPM_PIN_B0] <= swd_mode ? dbg_viewer : dbg_tdo; // [R5] [R13]
            pin_oe[`DTPM_PIN_B0] <= (swd_mode ? viewer_en : dbg_tdo_oe) & ~dbg_blocked &
                output_enable[`DTPM_PIN_B0]; // [R6] [R11] [R14]
        end
        if (sel_b1) begin
            pin_oe[`DTPM_PIN_B1] <= 1'b0; // [R7]
        end
        if (sel_b2) begin
            pin_oe[`DTPM_PIN_B2] <= 1'b0; // [R7]
        end
        if (trace_on) begin
            pin_out[`DTPM_PIN_A2] <= trace_clock; // [R8]
            pin_out[`DTPM_PIN_A6:`DTPM_PIN_A3] <= trace_nibble; // [R8]
            pin_oe[`DTPM_PIN_A6:`DTPM_PIN_A2] <= 5'h1F; // [R8]
        end
    end
end

endmodule // dtpm_pin_mux

`default_nettype wire

// ### dtpm_pin_mux_bench.sv
// Self-checking bench for the debug and trace pin multiplexer
`default_nettype none
module dtpm_pin_mux_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0, trc_data = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata;
    logic ext_rst_n = 1'b1, stop_mode = 1'b0, trc_valid = 1'b0, trc_ready;
    logic dbg_swdio_out = 1'b0, dbg_swdio_oe = 1'b0, dbg_tdo = 1'b0;
    logic dbg_tdo_oe = 1'b1, dbg_viewer = 1'b0;
    logic frame = 1'b0, swdio_drv = 1'b0, swdio_val = 1'b0;
    logic [9:0] gpio_out = 10'h000, board_oe = 10'h300, board_lvl = 10'h000;
    logic [9:0] pin_in, pin_out, pin_oe, pin_ie, pin_pu, pin_pd, gpio_in;
    logic tms, clk_lv, tdi, trst_n, swd_mode;
    logic [15:0] rst_tab [0:6] = '{16'h0383, 16'h0303, 16'h0081, 16'h0301, 16'h0002, 0, 0};
    integer err_count = 0, comparisons = 0, n, i;
    // ----------------------------------------
    // Clock, design and probe
    // ----------------------------------------
    always #12.5 core_clk = ~core_clk;
    dtpm_pin_mux DUT (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_ie(pin_ie),
        .pin_pull_up(pin_pu), .pin_pull_down(pin_pd), .ext_rst_n(ext_rst_n),
        .stop_mode(stop_mode), .gpio_out(gpio_out), .gpio_in(gpio_in),
        .dbg_tms_swdio(tms), .dbg_clk_level(clk_lv), .dbg_clk_rise(), .dbg_clk_fall(),
        .dbg_tdi(tdi), .dbg_trst_n(trst_n), .dbg_swd_mode(swd_mode),
        .dbg_swdio_out(dbg_swdio_out), .dbg_swdio_oe(dbg_swdio_oe), .dbg_tdo(dbg_tdo),
        .dbg_tdo_oe(dbg_tdo_oe), .dbg_viewer(dbg_viewer), .trc_data(trc_data),
        .trc_valid(trc_valid), .trc_ready(trc_ready));
    dtpm_probe u_probe (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pu),
        .pin_pull_down(pin_pd), .frame(frame), .swdio_drv(swdio_drv),
        .swdio_val(swdio_val), .board_oe(board_oe), .board_lvl(board_lvl), .pin_in(pin_in));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task final_report;
        if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data is taken in the one cycle that it stands
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask
    // One 800 ns frame of four serial clock periods, then a quiet tail
    task frame_cnt(output integer c);
        c = 0;
        @(posedge core_clk);
        frame <= 1'b1;
        for (int k = 0; k < 48; k++) begin
            @(posedge core_clk);
            if (k == 31) frame <= 1'b0;
            #1;
            if (DUT.dbg_clk_rise === 1'b1) c++;
        end
    endtask
    // Bounded wait for the next trace clock rise
    task wait_trc;
        integer k;
        logic p;
        p = 1'b1;
        k = 0;
        while (!(pin_out[2] === 1'b1 && !p) && k < 40) begin
            p = pin_out[2];
            @(posedge core_clk);
            #1;
            k++;
        end
        if (!(pin_out[2] === 1'b1 && !p)) begin
            err_count++;
            final_report;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 7; i++) rd(i[3:0], rst_tab[i]);
        rd(4'hF, 16'h0000);
        wr(4'h7, 16'hFFFF);
        rd(4'h7, 16'h0000);
        cyc(2);
        chk(pin_oe, 16'h0080);
        // JTAG: a0 input only, b0 carries the test data output
        @(posedge core_clk);
        {dbg_tdo, dbg_swdio_oe, swdio_drv} <= 3'b111;
        cyc(4);
        chk(pin_out[7], 1);
        chk(pin_oe[0], 0);
        chk({tms, tdi, trst_n}, 0);
        frame_cnt(n);
        chk(n[15:0], 4);
        // External reset hides all probe traffic
        @(posedge core_clk);
        ext_rst_n <= 1'b0;
        cyc(4);
        chk(tms, 1);
        rd(4'h7, 16'h0001);
        frame_cnt(n);
        chk(n[15:0], 0);
        @(posedge core_clk);
        {ext_rst_n, board_lvl, dbg_swdio_out} <= {1'b1, 10'h100, 1'b1};
        // Serial wire: b1 and b2 freed, a0 driven both ways
        wr(4'h5, 16'h0001);
        cyc(4);
        chk({tdi, trst_n, swd_mode}, 3'b111);
        chk(gpio_in[9:8], 2'b01);
        chk(pin_oe[0] & pin_out[0], 1);
        chk(pin_out[7], 0);
        wr(4'h5, 16'h0003);
        @(posedge core_clk);
        dbg_viewer <= 1'b1;
        cyc(2);
        chk(pin_out[7], 1);
        // STOP: debug drivers stay, port driver needs the standby bit
        @(posedge core_clk);
        {stop_mode, gpio_out} <= {1'b1, 10'h010};
        wr(4'h2, 16'h0091);
        cyc(2);
        chk({pin_oe[7], pin_oe[4], pin_oe[0]}, 3'b101);
        wr(4'h6, 16'h0001);
        cyc(2);
        chk(pin_oe[4], 1);
        @(posedge core_clk);
        stop_mode <= 1'b0;
        // Clock pin back to port use: debug sees idle clock
        wr(4'h0, 16'h0381);
        frame_cnt(n);
        chk({n[14:0], clk_lv}, 0);
        // Trace: fill while pins unselected, then drain in order
        @(posedge core_clk);
        {trc_valid, trc_data} <= {1'b1, 4'h5};
        @(posedge core_clk);
        trc_data <= 4'hA;
        @(posedge core_clk);
        trc_valid <= 1'b0;
        cyc(6);
        chk(trc_ready, 0);
        rd(4'h7, 16'h0004);
        wr(4'h0, 16'h03FD);
        wait_trc;
        chk({pin_oe[6:2], pin_out[6:3]}, {5'h1F, 4'h5});
        wait_trc;
        chk(pin_out[6:3], 4'hA);
        wait_trc;
        chk({trc_ready, pin_out[6:3]}, 5'h10);
        final_report;
    end
endmodule // dtpm_pin_mux_bench
`default_nettype wire

// ### dtpm_probe.sv
// Debug probe and board model resolving the multiplexer pads
`default_nettype none
module dtpm_probe (
    input wire logic [9:0] pin_out,
    input wire logic [9:0] pin_oe,
    input wire logic [9:0] pin_pull_up,
    input wire logic [9:0] pin_pull_down,
    input wire logic frame,
    input wire logic swdio_drv,
    input wire logic swdio_val,
    input wire logic [9:0] board_oe,
    input wire logic [9:0] board_lvl,
    output logic [9:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic swclk = 1'b0;
    // Serial clock runs only inside a frame and parks low between frames
    always begin
        #100;
        swclk = frame ? ~swclk : 1'b0;
    end
    // Device driver wins, then probe, board, pulls; a floating pad flips
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (i == 0 && swdio_drv) pin_in[i] = swdio_val;
            else if (i == 1) pin_in[i] = swclk;
            else if (board_oe[i]) pin_in[i] = board_lvl[i];
            else if (pin_pull_up[i]) pin_in[i] = 1'b1;
            else if (pin_pull_down[i]) pin_in[i] = 1'b0;
            else pin_in[i] = ~pin_out[i];
        end
    end
endmodule // dtpm_probe
`default_nettype wire

// ### dtpm_regs.vh
// Constants for the debug and trace pin multiplexer
`ifndef DTPM_REGS_VH
`define DTPM_REGS_VH

// ----------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------
`define DTPM_OFS_FUNC_SEL 4'h0
`define DTPM_OFS_INPUT_EN 4'h1
`define DTPM_OFS_OUTPUT_EN 4'h2
`define DTPM_OFS_PULL_UP 4'h3
`define DTPM_OFS_PULL_DOWN 4'h4
`define DTPM_OFS_DBG_CTRL 4'h5
`define DTPM_OFS_STANDBY 4'h6
`define DTPM_OFS_STATUS 4'h7
`define DTPM_OFS_PIN_LEVEL 4'h8

// ----------------------------------------------------------------
// Pin positions inside every 10-bit pin vector
// ----------------------------------------------------------------
`define DTPM_PIN_A0 0
`define DTPM_PIN_A1 1
`define DTPM_PIN_A2 2
`define DTPM_PIN_A3 3
`define DTPM_PIN_A6 6
`define DTPM_PIN_B0 7
`define DTPM_PIN_B1 8
`define DTPM_PIN_B2 9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTPM_CTRL_SWD_MODE 0
`define DTPM_CTRL_VIEWER_EN 1
`define DTPM_STBY_DRIVE 0
`define DTPM_STAT_EXT_RST 0
`define DTPM_STAT_BUF_LSB 1
`define DTPM_STAT_BUF_MSB 2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DTPM_RST_FUNC_SEL 10'h383
`define DTPM_RST_INPUT_EN 10'h303
`define DTPM_RST_OUTPUT_EN 10'h081
`define DTPM_RST_PULL_UP 10'h301
`define DTPM_RST_PULL_DOWN 10'h002
`define DTPM_RST_DBG_CTRL 2'h0
`define DTPM_RST_STANDBY 1'h0

// ----------------------------------------------------------------
// Timing: core cycles per half period of the trace clock
// ----------------------------------------------------------------
`define DTPM_TRC_HALF 4'h2

`endif
